// ### verification/fps_flash_model.sv
// Purpose: Behavioural flash device facing the host controller
// Assumes: Byte mode, no sector protection, no address decode
// Notes: lock models a non-blank target that never completes
`timescale 1ns/1ps
module fps_flash_model (
   input wire logic ce_n, // Chip select
   input wire logic we_n, // Write strobe
   input wire logic oe_n, // Output strobe
   input wire logic [7:0] dq, // Resolved data wire
   input wire logic lock, // Non-blank target
   output logic [7:0] q, // Data to host
   output logic rb_n // Ready/busy pin
);
   int wn = 0; // Unlock writes seen
   int busy = 0; // Reads left in algorithm
   int rc = 0; // Reads while stuck
   logic pg = 0, er = 0, tg = 0, to = 0; // Armed, erase, toggle, timeout
   logic [7:0] wd = 8'hff, v; // Written byte, status view
   // Command decode on the write strobe rise
   always @(posedge we_n) if (!ce_n) begin
      if (pg) begin
         wd = dq;
         busy = 6;
         pg = 0;
         er = 0;
      end else if (dq == 8'hf0) begin
         busy = 0;
         to = 0;
         rc = 0;
         wn = 0;
      end else if (wn == 2 && dq == 8'ha0) begin
         pg = 1;
         wn = 0;
      end else if (wn == 5) begin
         er = 1;
         busy = 6;
         wn = 0;
      end else wn = wn + 1;
   end
   // One toggle per finished read while busy
   always @(posedge oe_n) if (!ce_n && busy > 0) begin
      tg = ~tg;
      if (!lock) busy = busy - 1;
      else if (++rc > 3) to = 1;
   end
   // Status while busy, array data after
   // Every read falls in the chosen sector, so the sector toggle follows the erase
   assign v = (busy > 0) ? {er ? 1'b0 : ~wd[7], tg, to, 1'b0, er, er & tg, 2'h0}
      : (er ? 8'hff : wd);
   // Released bus shows inverse so stale data never passes
   assign q = (!ce_n && !oe_n) ? v : ~v;
   assign rb_n = !(busy > 0);
endmodule

// ### verification/fps_host_asserts.sv
// Purpose: Flash pin protocol checks for the host controller
// Assumes: Bound to fps_host, one clock domain
// Notes: Strobe timing follows the controller's own walk
`timescale 1ns/1ps
module fps_host_asserts (
   input wire logic clk, // System clock
   input wire logic rstn, // Async reset
   input wire logic fl_ce_n, // Chip select
   input wire logic fl_we_n, // Write strobe
   input wire logic fl_oe_n, // Output strobe
   input wire logic [19:0] fl_addr, // Address
   input wire logic [7:0] fl_dq_out, // Data out
   input wire logic fl_dq_oe // Data drive
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Half of the least read strobe
   sequence s_rd_half;
      (!fl_oe_n && !fl_ce_n) [*8];
   endsequence
   property p_we_ctx; !fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe; endproperty
   a_we_ctx: assert property (p_we_ctx) else $error("write strobe outside write");
   property p_we_len; $fell(fl_we_n) |-> !fl_we_n [*8]; endproperty
   a_we_len: assert property (p_we_len) else $error("write strobe too short");
   property p_setup; $fell(fl_we_n) |-> !$past(fl_ce_n, 3) && $stable(fl_addr); endproperty
   a_setup: assert property (p_setup) else $error("write setup short");
   property p_hold; $rose(fl_we_n) |-> $stable(fl_dq_out) && $stable(fl_addr) ##1 fl_ce_n;
   endproperty
   a_hold: assert property (p_hold) else $error("write data not held");
   property p_rd_ctx; !fl_oe_n |-> !fl_dq_oe && fl_we_n; endproperty
   a_rd_ctx: assert property (p_rd_ctx) else $error("bus clash on read");
   property p_rd_len; $fell(fl_oe_n) |-> s_rd_half ##1 s_rd_half; endproperty
   a_rd_len: assert property (p_rd_len) else $error("read strobe too short");
   property p_rd_end; $fell(fl_oe_n) |-> ##[17:60] fl_oe_n; endproperty
   a_rd_end: assert property (p_rd_end) else $error("read strobe stuck");
   property p_rd_ce; $rose(fl_oe_n) |=> fl_ce_n; endproperty
   a_rd_ce: assert property (p_rd_ce) else $error("select held after read");
endmodule
bind fps_host fps_host_asserts fps_host_asserts_inst (.clk(clk), .rstn(rstn), .fl_ce_n(fl_ce_n),
   .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
   .fl_dq_oe(fl_dq_oe));

// ### verification/test_fps_host.sv
// Purpose: Self-checking bench for the flash host controller
// Assumes: One wait state per bus access, model device on the pins
// Notes: Random bytes come from an 8-bit shift register seeded 24
`timescale 1ns/1ps
module test_fps_host;
   logic clk = 0, rstn = 0, rd = 0, wr = 0, lock = 0; // Clock, reset, bus, fault
   logic [4:0] adr = 5'h00; // Bus address
   logic [31:0] wdat = 32'h0, rdat, r; // Bus data
   logic [7:0] dqo, dqi, seed = 8'h18; // Data pins, random state
   logic [19:0] fa; // Flash address
   logic ce_n, we_n, oe_n, oe, wt, rb_n; // Strobes and flags
   wire [7:0] dqw = oe ? dqo : dqi; // Resolved data wire
   int fails = 0, check_count = 0; // Counters
   always #2 clk = ~clk;
   fps_host fps_host_inst (.clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wt),
      .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n), .fl_addr(fa), .fl_dq_out(dqo),
      .fl_dq_oe(oe), .fl_dq_in(dqw), .ready_busy_n_in(rb_n));
   fps_flash_model fps_flash_model_inst (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq(dqw),
      .lock(lock), .q(dqi), .rb_n(rb_n));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s exp %h seen %h", n, exp, seen);
      end
   endtask
   // One Avalon access, held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wt !== 1'b0 && n < 100);
      r = rdat;
      wr <= 0;
      rd <= 0;
      if (wt !== 1'b0) begin fails++; give_verdict; end
   endtask
   // Start an operation, poll until done, check status and captured byte
   task automatic run(input logic [2:0] op, input logic [7:0] d, st, m, e);
      int n;
      bus(1, 5'h04, {12'h0, d, d[3:0], 8'h00});
      bus(1, 5'h08, {24'h0, d});
      bus(1, 5'h00, 32'h8000_0000 | op);
      n = 0;
      do begin bus(0, 5'h0c, 0); n++; end while (r[1] !== 1'b1 && n < 3000);
      if (n >= 3000) begin fails++; give_verdict; end
      chk("status", r[4:0], st[4:0]);
      bus(0, 5'h10, 0);
      chk("rdata", r[7:0] & m, e);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1;
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         run(3'h1, seed, {3'h0, seed[3], 4'ha}, 8'hff, seed);
      end
      run(3'h1, 8'h80, 8'h0a, 8'hff, 8'h80);
      run(3'h1, 8'hf0, 8'h0a, 8'hff, 8'hf0);
      run(3'h2, 8'h00, 8'h1a, 8'hff, 8'hff);
      run(3'h3, 8'h33, 8'h1a, 8'hff, 8'hff);
      lock <= 1;
      run(3'h1, 8'h3c, 8'h0e, 8'ha0, 8'ha0);
      lock <= 0;
      run(3'h1, 8'h5a, 8'h1a, 8'hff, 8'h5a);
      // Suspend and resume while idle: no effect, resume still polls to array data
      run(3'h5, 8'h00, 8'h1a, 8'hff, 8'h5a);
      run(3'h6, 8'h00, 8'h1a, 8'hff, 8'h5a);
      run(3'h4, 8'h00, 8'h1a, 8'hff, 8'h5a);
      run(3'h7, 8'h00, 8'h1a, 8'hff, 8'h5a);
      bus(0, 5'h14, 0);
      chk("unmapped", r, 32'h0);
      give_verdict;
   end
endmodule

// ### verilog/fps_cyc_if.sv
// Purpose: Carries one flash bus cycle request between sequencer and engine
// Assumes: One request outstanding at a time
// Notes:   done is a one-cycle pulse, rdata valid with it
`timescale 1ns/1ps
interface fps_cyc_if #(
   parameter int AW = 20,
   parameter int DW = 8
);
   logic req; // Start a cycle, one-cycle pulse
   logic write; // 1 write cycle, 0 read cycle
   logic [AW-1:0] addr; // Cycle address
   logic [DW-1:0] wdata; // Write data
   logic done; // Cycle finished
   logic [DW-1:0] rdata; // Read data
   modport mst (output req, write, addr, wdata, input done, rdata);
   modport eng (input req, write, addr, wdata, output done, rdata);
endinterface

// ### verilog/fps_cycle.sv
// Purpose: Runs single read or write cycles on the parallel flash pins
// Assumes: Pins are idle high strobes between cycles
// Notes:   Read data passes a three stage synchroniser before capture
`timescale 1ns/1ps
module fps_cycle #(
   parameter int AW = 20,
   parameter int DW = 8
) (
   input wire logic clk, // System clock
   input wire logic rstn, // Async reset, active low
   fps_cyc_if.eng cyc, // Cycle requests
   output logic fl_ce_n, // Chip select
   output logic fl_we_n, // Write strobe
   output logic fl_oe_n, // Output strobe
   output logic [AW-1:0] fl_addr, // Address pins
   output logic [DW-1:0] fl_dq_out, // Data out
   output logic fl_dq_oe, // Data drive enable
   input wire logic [DW-1:0] fl_dq_in // Data in
);
   typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fps_eng_t;
   fps_eng_t st_q; // Engine state
   logic [7:0] cnt_q; // Phase counter
   logic wr_q; // Direction latched
   logic [DW-1:0] s1_q, s2_q, s3_q; // Data synchroniser

   // ----------------------------------------
   // Data input synchroniser
   // ----------------------------------------
   // s1 feeds s2 only; capture waits for s2 and s3 to agree
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= fl_dq_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ----------------------------------------
   // Cycle sequencing
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= E_IDLE;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         fl_ce_n <= 1'b1;
         fl_we_n <= 1'b1;
         fl_oe_n <= 1'b1;
         fl_addr <= '0;
         fl_dq_out <= '0;
         fl_dq_oe <= 1'b0;
         cyc.done <= 1'b0;
         cyc.rdata <= '0;
      end else begin
         cyc.done <= 1'b0;
         case (st_q)
            E_IDLE: begin
               if (cyc.req) begin
                  // Address and data set up before any strobe falls
                  fl_addr <= cyc.addr;
                  fl_dq_out <= cyc.wdata;
                  fl_dq_oe <= cyc.write;
                  wr_q <= cyc.write;
                  fl_ce_n <= 1'b0;
                  cnt_q <= 8'(fps_pkg::SETUP_CYC);
                  st_q <= E_SETUP;
               end
            end
            E_SETUP: begin
               if (cnt_q <= 8'h01) begin
                  fl_we_n <= ~wr_q;
                  fl_oe_n <= wr_q;
                  cnt_q <= wr_q ? 8'(fps_pkg::WRPULSE_CYC) : 8'(fps_pkg::RDACC_CYC);
                  st_q <= E_STROBE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            E_STROBE: begin
               if (cnt_q > 8'h01) begin
                  cnt_q <= cnt_q - 8'h01;
               end else if (wr_q || (s2_q == s3_q)) begin
                  // Write strobe rises first, so the device latches here
                  fl_we_n <= 1'b1;
                  fl_oe_n <= 1'b1;
                  if (!wr_q) begin
                     cyc.rdata <= s3_q;
                  end
                  cnt_q <= 8'(fps_pkg::HOLD_CYC);
                  st_q <= E_HOLD;
               end
            end
            E_HOLD: begin
               fl_ce_n <= 1'b1;
               if (cnt_q <= 8'h01) begin
                  fl_dq_oe <= 1'b0;
                  cyc.done <= 1'b1;
                  st_q <= E_IDLE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: st_q <= E_IDLE;
         endcase
      end
   end
endmodule

// ### verilog/fps_host.sv
// Purpose: Host controller issuing program/erase sequences and polling status
// Assumes: Avalon-MM slave with waitrequest, byte mode flash bus
// Notes:   Completion is judged by toggle polling, never by the pin alone
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
// Behaviour
// - Program entered by two unlocks, command, data
// - Host reads status twice, compares toggle bit
// - Toggling with timeout flag: recheck, then reset
// - Resumed polling restarts from double read
// - Reset command after timeout before new operation
module fps_host #(
   parameter int AW = fps_pkg::FL_ADDR_W, // Flash address width
   parameter int DW = fps_pkg::FL_DATA_W // Flash data width
) (
   input wire logic clk, // System clock, 250 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic [4:0] avs_address, // Avalon byte address
   input wire logic avs_read, // Avalon read
   input wire logic avs_write, // Avalon write
   input wire logic [31:0] avs_writedata, // Avalon write data
   output logic [31:0] avs_readdata, // Avalon read data
   output logic avs_waitrequest, // Avalon wait
   output logic fl_ce_n, // Flash chip select
   output logic fl_we_n, // Flash write strobe
   output logic fl_oe_n, // Flash output strobe
   output logic [AW-1:0] fl_addr, // Flash address
   output logic [DW-1:0] fl_dq_out, // Flash data out
   output logic fl_dq_oe, // Flash data drive enable
   input wire logic [DW-1:0] fl_dq_in, // Flash data in
   input wire logic ready_busy_n_in // Open-drain ready/busy level
);
   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (DW != 8 || AW < 12 || AW > 32) begin : g_bad_param
      $error("fps_host: byte mode with 12..32 address bits only");
   end

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   typedef enum logic [2:0] {
      S_IDLE, S_CMD, S_WAIT, S_POLL_A, S_POLL_B, S_JUDGE, S_DONE
   } fps_state_t;
   fps_state_t st_q; // Sequencer state
   fps_pkg::fps_op_t op_q; // Operation in progress
   logic [2:0] step_q; // Index into command sequence
   logic [AW-1:0] addr_q; // Target address register
   logic [DW-1:0] wdata_q; // Program data register
   logic [DW-1:0] rdata_q; // Last byte read
   logic [DW-1:0] first_q; // First status read of a pair
   logic recheck_q; // Second pair after timeout flag
   logic fail_cmd_q; // Reset write issued after failure
   logic busy_q, done_q, fail_q, win_q; // Status flags
   logic ack_q; // Avalon answer cycle
   logic [2:0] rb_sync_q; // Ready/busy synchroniser
   logic rdy_q; // Filtered ready level
   logic go; // Start write accepted
   logic [AW+DW:0] sw; // Command word for this step: {last, address, data}
   fps_cyc_if #(.AW(AW), .DW(DW)) cyc (); // Engine link

   // ----------------------------------------
   // Command sequence lookup
   // ----------------------------------------
   // Returns {last, address, data} for one write of an operation
   function automatic logic [AW+DW:0] seq_word(input fps_pkg::fps_op_t op,
                                              input logic [2:0] step,
                                              input logic [AW-1:0] ta,
                                              input logic [DW-1:0] td);
      logic [AW-1:0] a1;
      logic [AW-1:0] a2;
      logic [DW-1:0] cmd;
      a1 = AW'(fps_pkg::UNLOCK_ADDR1);
      a2 = AW'(fps_pkg::UNLOCK_ADDR2);
      cmd = fps_pkg::CMD_RESET;
      seq_word = {1'b1, ta, cmd};
      case (op)
         fps_pkg::OP_PROGRAM: begin
            // Two unlocks, program command, then address and data
            case (step)
               3'h0: seq_word = {1'b0, a1, fps_pkg::UNLOCK_DATA1};
               3'h1: seq_word = {1'b0, a2, fps_pkg::UNLOCK_DATA2};
               3'h2: seq_word = {1'b0, a1, fps_pkg::CMD_PROGRAM};
               default: seq_word = {1'b1, ta, td};
            endcase
         end
         fps_pkg::OP_CHIP_ERASE, fps_pkg::OP_SECTOR_ERASE: begin
            // Six writes; the last names chip or sector
            case (step)
               3'h0, 3'h3: seq_word = {1'b0, a1, fps_pkg::UNLOCK_DATA1};
               3'h1, 3'h4: seq_word = {1'b0, a2, fps_pkg::UNLOCK_DATA2};
               3'h2: seq_word = {1'b0, a1, fps_pkg::CMD_ERASE_SETUP};
               default: begin
                  if (op == fps_pkg::OP_CHIP_ERASE) begin
                     seq_word = {1'b1, a1, fps_pkg::CMD_CHIP_ERASE};
                  end else begin
                     seq_word = {1'b1, ta, fps_pkg::CMD_SECTOR_ERASE};
                  end
               end
            endcase
         end
         fps_pkg::OP_SUSPEND: seq_word = {1'b1, ta, fps_pkg::CMD_SUSPEND};
         fps_pkg::OP_RESUME: seq_word = {1'b1, ta, fps_pkg::CMD_RESUME};
         default: seq_word = {1'b1, ta, cmd};
      endcase
   endfunction

   // Operations whose completion must be polled
   function automatic logic needs_poll(input fps_pkg::fps_op_t op);
      needs_poll = (op == fps_pkg::OP_PROGRAM) || (op == fps_pkg::OP_CHIP_ERASE)
                   || (op == fps_pkg::OP_SECTOR_ERASE) || (op == fps_pkg::OP_RESUME);
   endfunction

   // One lookup shared by issue and advance; a call result cannot be bit-selected
   assign sw = seq_word(op_q, step_q, addr_q, wdata_q);

   // ----------------------------------------
   // Cycle engine
   // ----------------------------------------
   fps_cycle #(.AW(AW), .DW(DW)) u_cycle (
      .clk(clk),
      .rstn(rstn),
      .cyc(cyc),
      .fl_ce_n(fl_ce_n),
      .fl_we_n(fl_we_n),
      .fl_oe_n(fl_oe_n),
      .fl_addr(fl_addr),
      .fl_dq_out(fl_dq_out),
      .fl_dq_oe(fl_dq_oe),
      .fl_dq_in(fl_dq_in)
   );

   // ----------------------------------------
   // Ready/busy pin synchroniser
   // ----------------------------------------
   // Shown to software only; the sequencer never reads the pin, before or after the last write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rb_sync_q <= 3'h7;
         rdy_q <= 1'b1;
      end else begin
         rb_sync_q <= {rb_sync_q[1:0], ready_busy_n_in};
         if (rb_sync_q[1] == rb_sync_q[2]) begin
            rdy_q <= rb_sync_q[2];
         end
      end
   end

   // ----------------------------------------
   // Avalon slave
   // ----------------------------------------
   // One wait cycle per access keeps read data registered
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign go = avs_write & ack_q & (avs_address == fps_pkg::REG_CTRL)
               & avs_writedata[fps_pkg::CTRL_GO_BIT];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // Read mux; unmapped offsets read zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & ~ack_q) begin
         case (avs_address)
            fps_pkg::REG_CTRL: avs_readdata <= 32'(op_q);
            fps_pkg::REG_ADDR: avs_readdata <= 32'(addr_q);
            fps_pkg::REG_WDATA: avs_readdata <= 32'(wdata_q);
            fps_pkg::REG_STATUS: begin
               avs_readdata <= (32'(busy_q) << fps_pkg::ST_BUSY_BIT)
                  | (32'(done_q) << fps_pkg::ST_DONE_BIT)
                  | (32'(fail_q) << fps_pkg::ST_FAIL_BIT)
                  | (32'(rdy_q) << fps_pkg::ST_RDY_BIT)
                  | (32'(win_q) << fps_pkg::ST_WIN_BIT);
            end
            fps_pkg::REG_RDATA: avs_readdata <= 32'(rdata_q);
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // Address and data registers, frozen while busy
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_q <= '0;
         wdata_q <= '0;
      end else if (avs_write & ack_q & ~busy_q) begin
         if (avs_address == fps_pkg::REG_ADDR) begin
            addr_q <= avs_writedata[AW-1:0];
         end
         if (avs_address == fps_pkg::REG_WDATA) begin
            wdata_q <= avs_writedata[DW-1:0];
         end
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Issues command writes, then polls the toggle bit to a verdict
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= S_IDLE;
         op_q <= fps_pkg::OP_NONE;
         step_q <= 3'h0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         win_q <= 1'b0;
         rdata_q <= '0;
         first_q <= '0;
         recheck_q <= 1'b0;
         fail_cmd_q <= 1'b0;
         cyc.req <= 1'b0;
         cyc.write <= 1'b0;
         cyc.addr <= '0;
         cyc.wdata <= '0;
      end else begin
         cyc.req <= 1'b0;
         case (st_q)
            S_IDLE: begin
               // Start writes while busy are ignored
               if (go) begin
                  op_q <= fps_pkg::fps_op_t'(avs_writedata[fps_pkg::CTRL_OP_LSB +: 3]);
                  step_q <= 3'h0;
                  busy_q <= 1'b1;
                  done_q <= 1'b0;
                  fail_q <= 1'b0;
                  recheck_q <= 1'b0;
                  fail_cmd_q <= 1'b0;
                  st_q <= S_CMD;
               end
            end
            S_CMD: begin
               if (op_q == fps_pkg::OP_READ) begin
                  cyc.write <= 1'b0;
                  cyc.addr <= addr_q;
               end else begin
                  cyc.write <= 1'b1;
                  {cyc.addr, cyc.wdata} <= sw[AW+DW-1:0];
               end
               cyc.req <= 1'b1;
               st_q <= S_WAIT;
            end
            S_WAIT: begin
               if (cyc.done) begin
                  if (op_q == fps_pkg::OP_READ) begin
                     rdata_q <= cyc.rdata;
                     st_q <= S_DONE;
                  end else if (!sw[AW+DW]) begin
                     step_q <= step_q + 3'h1;
                     st_q <= S_CMD;
                  end else if (needs_poll(op_q) && !fail_cmd_q) begin
                     st_q <= S_POLL_A;
                  end else begin
                     st_q <= S_DONE;
                  end
               end
            end
            S_POLL_A: begin
               // First read of a pair, at the target address
               if (!cyc.req && cyc.done) begin
                  first_q <= cyc.rdata;
                  st_q <= S_POLL_B;
               end else if (!cyc.req) begin
                  cyc.write <= 1'b0;
                  cyc.addr <= addr_q;
                  cyc.req <= (step_q != 3'h7);
                  step_q <= 3'h7;
               end
            end
            S_POLL_B: begin
               if (step_q == 3'h7 && !cyc.req) begin
                  cyc.req <= 1'b1;
                  step_q <= 3'h6;
               end else if (cyc.done) begin
                  rdata_q <= cyc.rdata;
                  win_q <= cyc.rdata[fps_pkg::ERASE_WIN_POS];
                  st_q <= S_JUDGE;
               end
            end
            S_JUDGE: begin
               if (first_q[fps_pkg::TOGGLE_ONE_POS] == rdata_q[fps_pkg::TOGGLE_ONE_POS]) begin
                  st_q <= S_DONE;
               end else if (recheck_q) begin
                  // Still toggling after the flag: abandon with a reset write
                  fail_q <= 1'b1;
                  fail_cmd_q <= 1'b1;
                  op_q <= fps_pkg::OP_RESET;
                  step_q <= 3'h0;
                  st_q <= S_CMD;
               end else begin
                  // Any new pair starts again from its first read
                  recheck_q <= rdata_q[fps_pkg::TIMEOUT_POS];
                  step_q <= 3'h0;
                  st_q <= S_POLL_A;
               end
            end
            S_DONE: begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule

// ### verilog/fps_pkg.sv
// Purpose: Shared constants for the flash program/status host controller
// Assumes: 250 MHz clock, byte-wide parallel flash bus
// Notes:   Register map is word aligned; offsets are byte addresses
package fps_pkg;
   // ----------------------------------------
   // Clock and bus timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 4; // System clock period
   localparam int T_SETUP_NS = 10; // Address setup before a strobe
   localparam int T_WRPULSE_NS = 40; // Least write strobe low time
   localparam int T_RDACC_NS = 70; // Least read access time
   localparam int T_HOLD_NS = 20; // Hold and recovery after a strobe
   localparam int SYNC_STAGES = 3; // Pin input synchroniser depth
   // Least times round up to whole cycles
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRPULSE_CYC = (T_WRPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RDACC_CYC = (T_RDACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
   localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------
   // Flash bus widths
   // ----------------------------------------
   localparam int FL_ADDR_W = 20; // Byte address width
   localparam int FL_DATA_W = 8; // Byte mode data width
   // ----------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------
   localparam logic [4:0] REG_CTRL = 5'h00; // Operation code and start
   localparam logic [4:0] REG_ADDR = 5'h04; // Target address
   localparam logic [4:0] REG_WDATA = 5'h08; // Program data
   localparam logic [4:0] REG_STATUS = 5'h0c; // Controller state
   localparam logic [4:0] REG_RDATA = 5'h10; // Last byte read from flash
   // CTRL fields
   localparam int CTRL_OP_LSB = 0; // Operation code, 3 bits
   localparam int CTRL_GO_BIT = 31; // Start strobe, self clearing
   // STATUS fields
   localparam int ST_BUSY_BIT = 0; // Sequence in progress
   localparam int ST_DONE_BIT = 1; // Last sequence ended
   localparam int ST_FAIL_BIT = 2; // Last operation timed out
   localparam int ST_RDY_BIT = 3; // Synchronised ready/busy pin
   localparam int ST_WIN_BIT = 4; // Last seen erase window bit
   localparam logic [31:0] STATUS_RST = 32'h0000_0008; // Pin reads ready
   // ----------------------------------------
   // Flash status byte bit positions
   // ----------------------------------------
   localparam int POLL_STATUS_POS = 7; // poll_status_bit
   localparam int TOGGLE_ONE_POS = 6; // toggle_bit_one
   localparam int TIMEOUT_POS = 5; // timeout_flag_bit
   localparam int ERASE_WIN_POS = 3; // erase_window_bit
   // ----------------------------------------
   // Command bytes and unlock addresses
   // ----------------------------------------
   localparam logic [19:0] UNLOCK_ADDR1 = 20'h00555;
   localparam logic [19:0] UNLOCK_ADDR2 = 20'h002aa;
   localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
   localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_RESET = 8'hf0;
   // ----------------------------------------
   // Operation codes
   // ----------------------------------------
   typedef enum logic [2:0] {
      OP_NONE, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE,
      OP_RESET, OP_SUSPEND, OP_RESUME, OP_READ
   } fps_op_t;
endpackage
